// ===== rtl/pbm_boot_power_state_manager.sv
// Boot strap decode, power-state control and thermal supervision
// What this block does
// - Decode straps: high-voltage and safe pairs
// - Decode unconditional-sink pairs, sink on in every power state
// - Probe memory at 0x50, else await host
// - High-voltage policy enables sink at boot
// - High-voltage policy runs and enables PD
// - Request highest contract up to 20 V
// - High-voltage policy refused when memory loads
// - Safe policy keeps sink path off until configuration
// - Safe policy: PD off until configuration
// - Exactly one state: active, idle, standby, sleep
// - State changes autonomously, no software command
// - Idle only after inactivity of all events
// - Sleep watches attach and wakes on it
// - Path enables follow state and role
// - CC1 termination per state; CC2 open
// - Die and per-path sensors act independently
// - Die over-temperature disables all functions
// - Die shutdown releases after hysteresis drop
// - Path over-temperature disables all power paths
// - Path resume automatic or by firmware
module pbm_boot_power_state_manager
    import pbm_pkg::*;
(
    input  wire logic                  core_clk_i,
    input  wire logic                  rst_b_i,
    input  wire logic [2:0]            strap_input_one_i,
    input  wire logic [2:0]            strap_input_two_i,
    input  wire logic                  attach_i,
    input  wire logic                  eeprom_ack_i,
    input  wire logic                  eeprom_nack_i,
    input  wire logic                  eeprom_load_done_i,
    input  wire logic                  host_cfg_loaded_i,
    input  wire logic                  cfg_role_sink_i,
    input  wire logic                  cfg_source_only_i,
    input  wire logic [IDLE_CNT_W-1:0] idle_cycles_i,
    input  wire logic                  standby_req_i,
    input  wire logic                  pd_msg_i,
    input  wire logic                  cc_change_i,
    input  wire logic                  gpio_event_i,
    input  wire logic                  i2c_txn_i,
    input  wire logic                  volt_alert_i,
    input  wire logic                  fault_alert_i,
    input  wire logic [7:0]            die_temp_i,
    input  wire logic [7:0]            path_a_temp_i,
    input  wire logic [7:0]            path_b_temp_i,
    input  wire logic                  path_auto_resume_i,
    input  wire logic                  fw_path_reenable_i,
    output logic [1:0]                 addr_index_o,
    output logic [1:0]                 boot_policy_o,
    output logic                       strap_invalid_o,
    output logic                       eeprom_probe_o,
    output logic [6:0]                 eeprom_addr_o,
    output logic                       hv_policy_refused_o,
    output logic                       cfg_loaded_o,
    output logic                       normal_run_state_o,
    output logic                       pd_phy_en_o,
    output logic [15:0]                contract_max_mv_o,
    output logic                       source_only_o,
    output logic [1:0]                 power_state_o,
    output logic                       low_voltage_source_path_o,
    output logic                       high_voltage_sink_path_o,
    output logic                       external_sink_path_gate_o,
    output logic                       cable_supply_path_o,
    output logic [1:0]                 cc1_term_o,
    output logic [1:0]                 cc2_term_o,
    output logic                       die_shutdown_o,
    output logic                       path_shutdown_o
);
    // ==========================================================
    // Pin synchronisers and thermal sensors
    logic [5:0] strap_s;
    logic       attach_s;
    logic       die_hot;
    logic       path_a_hot;
    logic       path_b_hot;

    pbm_sync2 #(.W(6)) u_strap_sync (
        .core_clk_i (core_clk_i),
        .rst_b_i    (rst_b_i),
        .d_i        ({strap_input_one_i, strap_input_two_i}),
        .q_o        (strap_s)
    );
    pbm_sync2 #(.W(1)) u_attach_sync (
        .core_clk_i (core_clk_i),
        .rst_b_i    (rst_b_i),
        .d_i        (attach_i),
        .q_o        (attach_s)
    );
    pbm_thermal #(.THRESH(DIE_SHUTDOWN_THRESHOLD), .HYST(DIE_SHUTDOWN_HYSTERESIS)) u_die (
        .core_clk_i (core_clk_i),
        .rst_b_i    (rst_b_i),
        .temp_i     (die_temp_i),
        .hot_o      (die_hot)
    );
    pbm_thermal #(.THRESH(PATH_SHUTDOWN_THRESHOLD), .HYST(PATH_SHUTDOWN_HYSTERESIS)) u_pa (
        .core_clk_i (core_clk_i),
        .rst_b_i    (rst_b_i),
        .temp_i     (path_a_temp_i),
        .hot_o      (path_a_hot)
    );
    pbm_thermal #(.THRESH(PATH_SHUTDOWN_THRESHOLD), .HYST(PATH_SHUTDOWN_HYSTERESIS)) u_pb (
        .core_clk_i (core_clk_i),
        .rst_b_i    (rst_b_i),
        .temp_i     (path_b_temp_i),
        .hot_o      (path_b_hot)
    );

    // ==========================================================
    // Strap decode
    logic [1:0]  dec_idx;
    pbm_policy_t dec_pol;
    logic        dec_bad;

    always_comb begin
        dec_idx = IDX1;
        dec_pol = POL_SAFE_BOOT_NO_SINK;
        dec_bad = 1'b0;
        case (strap_s)
            {SV7, SV3}: begin dec_idx = IDX1; dec_pol = POL_NEGOTIATE_MAX_POWER_BOOT; end
            {SV3, SV3}: begin dec_idx = IDX2; dec_pol = POL_NEGOTIATE_MAX_POWER_BOOT; end
            {SV4, SV0}: begin dec_idx = IDX3; dec_pol = POL_NEGOTIATE_MAX_POWER_BOOT; end
            {SV3, SV7}: begin dec_idx = IDX4; dec_pol = POL_NEGOTIATE_MAX_POWER_BOOT; end
            {SV7, SV0}: dec_idx = IDX1;
            {SV0, SV0}: dec_idx = IDX2;
            {SV6, SV0}: dec_idx = IDX3;
            {SV5, SV7}: dec_idx = IDX4;
            {SV7, SV5}: begin dec_idx = IDX1; dec_pol = POL_UNCONDITIONAL_SINK_BOOT; end
            {SV5, SV5}: begin dec_idx = IDX2; dec_pol = POL_UNCONDITIONAL_SINK_BOOT; end
            {SV2, SV0}: begin dec_idx = IDX3; dec_pol = POL_UNCONDITIONAL_SINK_BOOT; end
            {SV1, SV7}: begin dec_idx = IDX4; dec_pol = POL_UNCONDITIONAL_SINK_BOOT; end
            // Unknown pairs fall back to the safe policy, which does not sink before configuration
            default:    dec_bad = 1'b1;
        endcase
    end

    // ==========================================================
    // Boot sequence
    typedef enum logic [2:0] {
        BS_STRAP,
        BS_PROBE,
        BS_LOAD,
        BS_HOST,
        BS_RUN
    } pbm_boot_t;

    pbm_boot_t   bs_r;
    logic [3:0]  settle_r;
    pbm_policy_t pol_r;
    logic [1:0]  idx_r;
    logic        bad_r;
    logic        refused_r;

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            bs_r      <= BS_STRAP;
            settle_r  <= 4'h0;
            pol_r     <= POL_SAFE_BOOT_NO_SINK;
            idx_r     <= IDX1;
            bad_r     <= 1'b0;
            refused_r <= 1'b0;
        end else begin
            case (bs_r)
                BS_STRAP: begin
                    settle_r <= settle_r + 4'h1;
                    if (settle_r == STRAP_SETTLE) begin
                        pol_r <= dec_pol;
                        idx_r <= dec_idx;
                        bad_r <= dec_bad;
                        bs_r  <= BS_PROBE;
                    end
                end
                BS_PROBE: begin
                    if (eeprom_ack_i) begin
                        bs_r <= BS_LOAD;
                        if (pol_r == POL_NEGOTIATE_MAX_POWER_BOOT) begin
                            pol_r     <= POL_SAFE_BOOT_NO_SINK;
                            refused_r <= 1'b1;
                        end
                    end else if (eeprom_nack_i) begin
                        bs_r <= BS_HOST;
                    end
                end
                BS_LOAD: if (eeprom_load_done_i) bs_r <= BS_RUN;
                BS_HOST: if (host_cfg_loaded_i) bs_r <= BS_RUN;
                BS_RUN:  bs_r <= BS_RUN;
                default: bs_r <= BS_STRAP;
            endcase
        end
    end

    // ==========================================================
    // Power-state machine, runs on its own events only
    pbm_pstate_t           ps_r;
    logic [IDLE_CNT_W-1:0] idle_cnt_r;
    logic                  activity;

    assign activity = pd_msg_i | cc_change_i | gpio_event_i | i2c_txn_i
                    | volt_alert_i | fault_alert_i;

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            idle_cnt_r <= '0;
        end else if (ps_r != PS_ACTIVE || activity) begin
            idle_cnt_r <= '0;
        end else if (idle_cnt_r != idle_cycles_i) begin
            idle_cnt_r <= idle_cnt_r + 1'b1;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ps_r <= PS_ACTIVE;
        end else begin
            case (ps_r)
                PS_ACTIVE: if (!activity && idle_cnt_r == idle_cycles_i) ps_r <= PS_IDLE;
                PS_IDLE: begin
                    if (activity) ps_r <= PS_ACTIVE;
                    else if (!attach_s) ps_r <= PS_SLEEP;
                    else if (standby_req_i) ps_r <= PS_STANDBY;
                end
                PS_STANDBY: begin
                    if (activity || !standby_req_i) ps_r <= PS_ACTIVE;
                    else if (!attach_s) ps_r <= PS_SLEEP;
                end
                PS_SLEEP: if (attach_s || activity) ps_r <= PS_ACTIVE;
                default: ps_r <= PS_ACTIVE;
            endcase
        end
    end

    // ==========================================================
    // Path-level thermal latch; a new overheat wins over re-enable
    logic path_off_r;

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            path_off_r <= 1'b0;
        end else if (path_a_hot || path_b_hot) begin
            path_off_r <= 1'b1;
        end else if (path_auto_resume_i || fw_path_reenable_i) begin
            path_off_r <= 1'b0;
        end
    end

    // ==========================================================
    // Output stage
    logic loaded;
    logic role_sink;
    logic full_pw;
    logic src_en;
    logic snk_en;
    logic run_en;

    assign loaded    = (bs_r == BS_RUN);
    // Before a configuration arrives the port can only sink
    assign role_sink = loaded ? (cfg_role_sink_i & ~cfg_source_only_i) : 1'b1;
    assign full_pw   = (ps_r == PS_ACTIVE) || (ps_r == PS_IDLE);
    // The source path also stays up in standby, so only sleep drops it
    assign src_en    = !role_sink && (ps_r != PS_SLEEP);
    assign snk_en    = (pol_r == POL_UNCONDITIONAL_SINK_BOOT)
                    || (full_pw && role_sink
                        && (pol_r == POL_NEGOTIATE_MAX_POWER_BOOT || loaded));
    assign run_en    = loaded || (pol_r == POL_NEGOTIATE_MAX_POWER_BOOT);

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            addr_index_o              <= IDX1;
            boot_policy_o             <= 2'h0;
            strap_invalid_o           <= 1'b0;
            eeprom_probe_o            <= 1'b0;
            eeprom_addr_o             <= EEPROM_ADDR;
            hv_policy_refused_o       <= 1'b0;
            cfg_loaded_o              <= 1'b0;
            normal_run_state_o        <= 1'b0;
            pd_phy_en_o               <= 1'b0;
            contract_max_mv_o         <= MAX_MV_NONE;
            source_only_o             <= 1'b0;
            power_state_o             <= 2'h0;
            low_voltage_source_path_o <= 1'b0;
            high_voltage_sink_path_o  <= 1'b0;
            external_sink_path_gate_o <= 1'b0;
            cable_supply_path_o       <= 1'b0;
            cc1_term_o                <= CC_OPEN;
            cc2_term_o                <= CC_OPEN;
            die_shutdown_o            <= 1'b0;
            path_shutdown_o           <= 1'b0;
        end else begin
            addr_index_o        <= idx_r;
            boot_policy_o       <= pol_r;
            strap_invalid_o     <= bad_r;
            eeprom_probe_o      <= (bs_r == BS_PROBE);
            hv_policy_refused_o <= refused_r;
            cfg_loaded_o        <= loaded;
            power_state_o       <= ps_r;
            source_only_o       <= loaded && cfg_source_only_i;
            die_shutdown_o      <= die_hot;
            path_shutdown_o     <= path_off_r;
            normal_run_state_o  <= run_en && !die_hot;
            pd_phy_en_o         <= run_en && !die_hot;
            contract_max_mv_o   <= (pol_r == POL_NEGOTIATE_MAX_POWER_BOOT)
                                   ? MAX_MV_NEG : MAX_MV_NONE;
            low_voltage_source_path_o <= src_en && !die_hot && !path_off_r;
            high_voltage_sink_path_o  <= snk_en && !die_hot && !path_off_r;
            external_sink_path_gate_o <= snk_en && !die_hot && !path_off_r;
            cable_supply_path_o       <= full_pw && !die_hot && !path_off_r;
            if (die_hot || !full_pw) cc1_term_o <= CC_OPEN;
            else if (role_sink) cc1_term_o <= CC_RP_3A0;
            else cc1_term_o <= CC_RD;
            cc2_term_o <= CC_OPEN;
        end
    end

    // ==========================================================
    // Assertions
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);

    a_strap_hv_pair: assert property ((bs_r == BS_STRAP && settle_r == STRAP_SETTLE
        && strap_s == {SV7, SV3}) |=> ##1 (addr_index_o == IDX1
        && boot_policy_o == POL_NEGOTIATE_MAX_POWER_BOOT))
        else $error("high-voltage strap pair decoded wrongly");
    a_eeprom_addr: assert property (eeprom_probe_o |-> eeprom_addr_o == 7'h50
        && $past(bs_r) == BS_PROBE)
        else $error("memory probe at wrong address or outside probing");
    a_safe_no_sink: assert property ((boot_policy_o == POL_SAFE_BOOT_NO_SINK
        && !cfg_loaded_o) |-> !high_voltage_sink_path_o && !pd_phy_en_o)
        else $error("safe policy enabled sink or PD");
    a_idle_wake: assert property ((ps_r == PS_IDLE && activity) |=> ps_r == PS_ACTIVE)
        else $error("activity did not wake from idle");
    a_no_early_idle: assert property ((ps_r == PS_ACTIVE && activity)
        |=> ps_r == PS_ACTIVE ##1 ps_r == PS_ACTIVE)
        else $error("idle entered right after activity");
    a_sleep_wake: assert property ((ps_r == PS_SLEEP && attach_s) |=> ps_r == PS_ACTIVE)
        else $error("attach did not leave sleep");
    a_cable_low_pw: assert property ((power_state_o == PS_STANDBY
        || power_state_o == PS_SLEEP) |-> !cable_supply_path_o && cc1_term_o == CC_OPEN)
        else $error("cable supply or CC1 active in low power");
    a_cc2_open: assert property (cc2_term_o == CC_OPEN)
        else $error("CC2 not open");
    a_die_kill: assert property ($rose(die_hot) |=> die_shutdown_o && !pd_phy_en_o
        && !low_voltage_source_path_o && !high_voltage_sink_path_o && !cable_supply_path_o)
        else $error("die shutdown left a function on");
    a_path_kill: assert property ((path_a_hot || path_b_hot) |=> ##1 (path_shutdown_o
        && !low_voltage_source_path_o && !high_voltage_sink_path_o && !cable_supply_path_o))
        else $error("path shutdown left a path on");
    a_path_hold: assert property ((path_off_r && !path_auto_resume_i && !fw_path_reenable_i)
        |=> path_off_r)
        else $error("path resumed without permission");
endmodule : pbm_boot_power_state_manager

// ===== rtl/pbm_pkg.sv
// Shared constants and types for the boot and power-state manager
package pbm_pkg;
    // ==========================================================
    // Boot timing and external memory
    localparam logic [3:0]  STRAP_SETTLE   = 4'h4;
    localparam logic [6:0]  EEPROM_ADDR    = 7'h50;
    localparam logic [15:0] MAX_MV_NEG     = 16'h4E20;
    localparam logic [15:0] MAX_MV_NONE    = 16'h0000;
    localparam int          IDLE_CNT_W     = 24;
    // ==========================================================
    // Thermal thresholds, codes of the on-die sensor
    localparam logic [7:0]  DIE_SHUTDOWN_THRESHOLD  = 8'h96;
    localparam logic [7:0]  DIE_SHUTDOWN_HYSTERESIS = 8'h14;
    localparam logic [7:0]  PATH_SHUTDOWN_THRESHOLD  = 8'h8C;
    localparam logic [7:0]  PATH_SHUTDOWN_HYSTERESIS = 8'h0F;
    // ==========================================================
    // Strap values and address indexes
    localparam logic [2:0]  SV0 = 3'h0;
    localparam logic [2:0]  SV1 = 3'h1;
    localparam logic [2:0]  SV2 = 3'h2;
    localparam logic [2:0]  SV3 = 3'h3;
    localparam logic [2:0]  SV4 = 3'h4;
    localparam logic [2:0]  SV5 = 3'h5;
    localparam logic [2:0]  SV6 = 3'h6;
    localparam logic [2:0]  SV7 = 3'h7;
    localparam logic [1:0]  IDX1 = 2'h0;
    localparam logic [1:0]  IDX2 = 2'h1;
    localparam logic [1:0]  IDX3 = 2'h2;
    localparam logic [1:0]  IDX4 = 2'h3;
    // ==========================================================
    // Enumerations
    typedef enum logic [1:0] {
        POL_SAFE_BOOT_NO_SINK,
        POL_NEGOTIATE_MAX_POWER_BOOT,
        POL_UNCONDITIONAL_SINK_BOOT
    } pbm_policy_t;
    typedef enum logic [1:0] {
        PS_ACTIVE,
        PS_IDLE,
        PS_STANDBY,
        PS_SLEEP
    } pbm_pstate_t;
    typedef enum logic [1:0] {
        CC_OPEN,
        CC_RD,
        CC_RP_3A0
    } pbm_cc_t;
endpackage : pbm_pkg

// ===== rtl/pbm_sync2.sv
// Two-flop synchroniser for pin inputs
module pbm_sync2 #(
    parameter int W = 1
) (
    input  wire logic         core_clk_i,
    input  wire logic         rst_b_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta_r;

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            meta_r <= '0;
            q_o    <= '0;
        end else begin
            meta_r <= d_i;
            q_o    <= meta_r;
        end
    end
endmodule : pbm_sync2

// ===== rtl/pbm_thermal.sv
// Over-temperature comparator with hysteresis
module pbm_thermal #(
    parameter logic [7:0] THRESH = 8'h80,
    parameter logic [7:0] HYST   = 8'h10
) (
    input  wire logic       core_clk_i,
    input  wire logic       rst_b_i,
    input  wire logic [7:0] temp_i,
    output logic            hot_o
);
    // Low release point saturates so a large hysteresis cannot wrap
    localparam logic [7:0] RELEASE = (THRESH > HYST) ? 8'(THRESH - HYST) : 8'h00;

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            hot_o <= 1'b0;
        end else if (temp_i > THRESH) begin
            hot_o <= 1'b1;
        end else if (temp_i < RELEASE) begin
            hot_o <= 1'b0;
        end
    end
endmodule : pbm_thermal

// ===== testbench/pbm_port_partner.sv
// Port partner model: plug state seen on CC after a short or long settle
module pbm_port_partner (
    input  wire logic core_clk_i,
    input  wire logic plug_i,
    input  wire logic slow_i,
    output logic      attach_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] hist_r = 8'h00;
    always @(posedge core_clk_i) begin
        hist_r <= {hist_r[6:0], plug_i};
    end
    // A slow partner settles its CC pull only after eight cycles
    assign attach_o = slow_i ? hist_r[7] : hist_r[0];
endmodule : pbm_port_partner

// ===== testbench/pbm_boot_power_state_manager_tb_top.sv
// Self-checking bench for the boot and power-state manager
module pbm_boot_power_state_manager_tb_top;
    import pbm_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // Stimulus and observed signals
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic [2:0]  s1 = 3'h0, s2 = 3'h0;
    logic        plug = 1'b1, slow = 1'b0, att, ack = 1'b0, nack = 1'b0, ld = 1'b0, hld = 1'b0;
    logic        snk = 1'b1, so = 1'b0, stby = 1'b0, ar = 1'b0, fw = 1'b0;
    logic        pd = 1'b0, ccc = 1'b0, gp = 1'b0, i2c = 1'b0, vlt = 1'b0, flt = 1'b0;
    logic [23:0] idle_n = 24'h000010;
    logic [7:0]  t_d = 8'h40, t_a = 8'h40, t_b = 8'h40;
    logic [1:0]  idx, pol, ps, cc1, cc2;
    logic        inv, probe, refd, cfgd, run, phy, srco, lvsp, hvsp, exsg, cab, dsd, psd;
    logic [6:0]  eaddr;
    logic [15:0] mv;
    int          fail_count = 0, cmp_count = 0, cyc = 0, seed = 32'h5d2ad084;
    int          tab_a[12] = '{7, 3, 4, 3, 7, 0, 6, 5, 7, 5, 2, 1};
    int          tab_b[12] = '{3, 3, 0, 7, 0, 0, 0, 7, 5, 5, 0, 7};
    int          tab_p[3] = '{1, 0, 2};
    always #2.5 clk = ~clk;
    pbm_port_partner u_pbm_port_partner (.core_clk_i(clk), .plug_i(plug), .slow_i(slow),
        .attach_o(att));
    pbm_boot_power_state_manager u_pbm_boot_power_state_manager (
        .core_clk_i(clk), .rst_b_i(rst_b), .strap_input_one_i(s1), .strap_input_two_i(s2),
        .attach_i(att), .eeprom_ack_i(ack), .eeprom_nack_i(nack), .eeprom_load_done_i(ld),
        .host_cfg_loaded_i(hld), .cfg_role_sink_i(snk), .cfg_source_only_i(so),
        .idle_cycles_i(idle_n), .standby_req_i(stby), .pd_msg_i(pd), .cc_change_i(ccc),
        .gpio_event_i(gp), .i2c_txn_i(i2c), .volt_alert_i(vlt), .fault_alert_i(flt),
        .die_temp_i(t_d), .path_a_temp_i(t_a), .path_b_temp_i(t_b),
        .path_auto_resume_i(ar), .fw_path_reenable_i(fw), .addr_index_o(idx),
        .boot_policy_o(pol), .strap_invalid_o(inv), .eeprom_probe_o(probe),
        .eeprom_addr_o(eaddr), .hv_policy_refused_o(refd), .cfg_loaded_o(cfgd),
        .normal_run_state_o(run), .pd_phy_en_o(phy), .contract_max_mv_o(mv),
        .source_only_o(srco), .power_state_o(ps), .low_voltage_source_path_o(lvsp),
        .high_voltage_sink_path_o(hvsp), .external_sink_path_gate_o(exsg),
        .cable_supply_path_o(cab), .cc1_term_o(cc1), .cc2_term_o(cc2),
        .die_shutdown_o(dsd), .path_shutdown_o(psd));
    // ==========================================================
    // Shared tasks
    task automatic test_done();
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : test_done
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            test_done();
        end
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic boot(input logic [2:0] a, input logic [2:0] b);
        rst_b = 1'b0;
        s1 = a;
        s2 = b;
        repeat (2) @(negedge clk);
        rst_b = 1'b1;
        repeat (12) @(negedge clk);
    endtask : boot
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask : tick
    task automatic wait_ps(input logic [1:0] e);
        int n = 0;
        while (ps !== e && n < 40) begin
            @(negedge clk);
            n++;
        end
        chk(ps, e);
    endtask : wait_ps
    // Any one of the six wake sources, picked at random
    task automatic act();
        int k;
        k = $unsigned($random(seed)) % 6;
        {pd, ccc, gp, i2c, vlt, flt} = 6'h01 << k;
        tick(1);
        {pd, ccc, gp, i2c, vlt, flt} = 6'h00;
    endtask : act
    task automatic path_chk(input logic s, input logic k, input logic c, input logic [1:0] t);
        chk(lvsp, s);
        chk(hvsp, k);
        chk(cab, c);
        chk(cc1, t);
        chk(cc2, CC_OPEN);
    endtask : path_chk
    // ==========================================================
    // Main sequence
    initial begin
        int i, p;
        for (i = 0; i < 13; i++) begin
            p = (i < 12) ? tab_p[i / 4] : 0;
            boot((i < 12) ? tab_a[i] : 6, (i < 12) ? tab_b[i] : 6);
            chk(idx, (i < 12) ? i % 4 : 0);
            chk(pol, p);
            chk(inv, i == 12);
            chk(exsg, p != 0);
            path_chk(1'b0, p != 0, 1'b1, CC_RP_3A0);
            chk(mv, (p == 1) ? 16'h4E20 : 16'h0000);
            if (p != 1) chk(phy, 1'b0);
            chk(probe, 1'b1);
            chk(eaddr, 7'h50);
        end
        boot(3'h7, 3'h3);
        ack = 1'b1;
        tick(1);
        ack = 1'b0;
        tick(3);
        chk(refd, 1'b1);
        chk(pol, POL_SAFE_BOOT_NO_SINK);
        chk(cfgd, 1'b0);
        ld = 1'b1;
        tick(1);
        ld = 1'b0;
        tick(3);
        chk(cfgd, 1'b1);
        chk(phy, 1'b1);
        chk(run, 1'b1);
        boot(3'h7, 3'h0);
        nack = 1'b1;
        tick(1);
        nack = 1'b0;
        tick(4);
        chk(probe, 1'b0);
        chk(cfgd, 1'b0);
        snk = 1'b0;
        so = 1'b1;
        hld = 1'b1;
        tick(1);
        hld = 1'b0;
        tick(3);
        chk(cfgd, 1'b1);
        chk(srco, 1'b1);
        act();
        wait_ps(PS_ACTIVE);
        path_chk(1'b1, 1'b0, 1'b1, CC_RD);
        tick(12);
        chk(ps, PS_ACTIVE);
        wait_ps(PS_IDLE);
        path_chk(1'b1, 1'b0, 1'b1, CC_RD);
        stby = 1'b1;
        wait_ps(PS_STANDBY);
        path_chk(1'b1, 1'b0, 1'b0, CC_OPEN);
        act();
        stby = 1'b0;
        wait_ps(PS_ACTIVE);
        wait_ps(PS_IDLE);
        slow = 1'b1;
        plug = 1'b0;
        wait_ps(PS_SLEEP);
        path_chk(1'b0, 1'b0, 1'b0, CC_OPEN);
        plug = 1'b1;
        wait_ps(PS_ACTIVE);
        t_d = 8'h97;
        tick(4);
        chk(dsd, 1'b1);
        path_chk(1'b0, 1'b0, 1'b0, CC_OPEN);
        t_d = 8'h83;
        tick(4);
        chk(dsd, 1'b1);
        t_d = 8'h81;
        tick(4);
        chk(dsd, 1'b0);
        chk(lvsp, 1'b1);
        t_a = 8'h8D;
        tick(4);
        chk(psd, 1'b1);
        chk(dsd, 1'b0);
        path_chk(1'b0, 1'b0, 1'b0, CC_RD);
        t_a = 8'h7E;
        fw = 1'b1;
        tick(1);
        fw = 1'b0;
        tick(4);
        chk(psd, 1'b1);
        t_a = 8'h70;
        tick(4);
        chk(psd, 1'b1);
        fw = 1'b1;
        tick(1);
        fw = 1'b0;
        tick(4);
        chk(psd, 1'b0);
        ar = 1'b1;
        t_b = 8'h8D;
        tick(4);
        chk(psd, 1'b1);
        t_b = 8'h70;
        tick(5);
        chk(psd, 1'b0);
        test_done();
    end
endmodule : pbm_boot_power_state_manager_tb_top
